/* File: rtl/sctp_regs.svh */
/*
  register offsets, field positions, reset codes and timing figures
  of the clock trim and prescaler block; assumes a 100 MHz pclk
*/
`ifndef SCTP_REGS_SVH
`define SCTP_REGS_SVH

// byte addresses on the apb window
`define SCTP_ADDR_W 12
`define SCTP_OFS_TRIM 12'h000
`define SCTP_OFS_DIVCTL 12'h004
`define SCTP_OFS_CFG 12'h008
`define SCTP_OFS_STATUS 12'h00C

// clock_divide_control fields
`define SCTP_UNLOCK_BIT 7
`define SCTP_SEL_MSB 3
`define SCTP_UNLOCK_PATTERN 8'h80
`define SCTP_UNLOCK_CYC 3'h4
`define SCTP_SEL_DIV1 4'h0
`define SCTP_SEL_FUSE_INIT 4'h4
`define SCTP_SEL_MAX 4'h8

// config and status fields
`define SCTP_CFG_TSYNC_BIT 0
`define SCTP_ST_DONE_BIT 8
`define SCTP_ST_EXT_BIT 9

// fuse codes
`define SCTP_SRC_EXTERNAL 4'h0
`define SCTP_SUT_NONE 2'h0
`define SCTP_SUT_SHORT 2'h1
`define SCTP_SUT_LONG 2'h2

// timing
`define SCTP_WAKE_CK 3'h6
`define SCTP_SYNC_CYC 2'h2
`define SCTP_CLK_NS 10
`define SCTP_DLY_SHORT_US 4100
`define SCTP_DLY_LONG_US 65000
`define SCTP_DLY_W 23

`endif

/* File: rtl/sctp_pkg.sv */
/*
  types shared by the clock trim and prescaler block;
  assumes the constants of sctp_regs.svh
*/
package sctp_pkg;

  // fuse bundle, each bit high when programmed
  typedef struct packed {
    logic [3:0] source_sel;
    logic [1:0] startup_time;
    logic clock_output;
    logic initial_divide;
  } sctp_fuse_type;

  // power-up sequence
  typedef enum logic [1:0] {
    ST_SYNC,
    ST_LOAD,
    ST_DELAY,
    ST_RUN
  } sctp_state_type;

endpackage : sctp_pkg

/* File: rtl/sctp_divider.sv */
/*
  glitch-free power-of-two divider producing a one-cycle tick and a
  square wave; assumes div_sel comes from pclk logic
*/
`timescale 1ns/1ps
`include "sctp_regs.svh"

module sctp_divider #(
  parameter int CNT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] div_sel,
  output logic tick,
  output logic div_clk
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;
  logic div_clk_ff;
  logic nxt_div_clk;

  // factor minus one; reserved codes fall back to the largest factor
  function automatic logic [CNT_W-1:0] factor_m1(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > `SCTP_SEL_MAX) ? `SCTP_SEL_MAX : sel;
    factor_m1 = CNT_W'((1 << s) - 1);
  endfunction : factor_m1

  // new factor is taken only at a period boundary, so no short pulse
  always_comb begin
    nxt_tick = (cnt_ff == '0);
    nxt_cnt = cnt_ff - CNT_W'(1);
    nxt_div_clk = div_clk_ff;
    if (cnt_ff == '0) begin
      nxt_cnt = factor_m1(div_sel);
      nxt_div_clk = ~div_clk_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
      div_clk_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
      div_clk_ff <= nxt_div_clk;
    end
  end

  assign tick = tick_ff;
  assign div_clk = div_clk_ff;

endmodule : sctp_divider

/* File: rtl/sctp_top.sv */
/*
  clock trim, source selection, start-up delay, clock output and
  timed-unlock system prescaler behind an apb slave.
  assumes fuses and calibration byte are static pins from outside
  the pclk domain, and that pclk stands for the selected source.
*/
// The register addresses and register access over APB were left to the implementer.
// Behaviour
// - calibration byte loaded into trim at reset
// - trim zero slowest, 0x7F fastest
// - source fuses 0000 select external clock
// - 6 CK wake, reset delay per fuses
// - clock output fuse drives system clock out; the pin carries div_clk, a square wave at half the tick rate
// - clock output carries the divided clock
// - prescaler divides system clocks, timer if synchronous
// - unlock bit 7, zeros 6-4, select 3-0
// - unlock self-clears after four cycles or write
// - only unlock then value within four accepted
// - open unlock window blocks interrupts
// - select codes 0-8 give factors 1-256
// - initial select from initial-divide fuse
// - any select value accepted through the sequence
`timescale 1ns/1ps
`include "sctp_regs.svh"

module sctp_top #(
  parameter int DLY_SHORT_CYC = `SCTP_DLY_SHORT_US * 1000 / `SCTP_CLK_NS,
  parameter int DLY_LONG_CYC = `SCTP_DLY_LONG_US * 1000 / `SCTP_CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SCTP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sctp_pkg::sctp_fuse_type fuse_in,
  input wire logic [7:0] calibration_byte,
  input wire logic wake_request,
  output logic [7:0] trim_value,
  output logic ext_clock_select,
  output logic startup_done,
  output logic wake_ready,
  output logic sys_clock_en,
  output logic async_timer_clock_en,
  output logic irq_block,
  output logic portb0_out,
  output logic portb0_oe
);

  // pin synchronisers
  sctp_pkg::sctp_fuse_type fuse_s1_ff;
  sctp_pkg::sctp_fuse_type fuse_ff;
  logic [7:0] cal_s1_ff;
  logic [7:0] cal_ff;

  // start-up sequence
  sctp_pkg::sctp_state_type state_ff;
  sctp_pkg::sctp_state_type nxt_state;
  logic [`SCTP_DLY_W-1:0] dly_cnt_ff;
  logic [`SCTP_DLY_W-1:0] nxt_dly_cnt;

  // registers and bus
  logic [7:0] trim_ff;
  logic [7:0] nxt_trim;
  logic [3:0] sel_ff;
  logic [3:0] nxt_sel;
  logic [2:0] win_ff;
  logic [2:0] nxt_win;
  logic tsync_ff;
  logic nxt_tsync;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;

  // outputs and wake
  logic [2:0] wake_cnt_ff;
  logic [2:0] nxt_wake_cnt;
  logic wake_ready_ff;
  logic nxt_wake_ready;
  logic sys_en_ff;
  logic timer_en_ff;
  logic clkout_ff;
  logic clkout_oe_ff;
  logic ext_sel_ff;
  logic irq_block_ff;

  logic div_tick;
  logic div_clk;
  logic wr_go;
  logic acc;
  logic [7:0] wbyte;

  // address decode used by the error path; read and write decode paddr in their own case statements
  function automatic logic addr_mapped(input logic [`SCTP_ADDR_W-1:0] a);
    addr_mapped = (a == `SCTP_OFS_TRIM) || (a == `SCTP_OFS_DIVCTL) ||
                  (a == `SCTP_OFS_CFG) || (a == `SCTP_OFS_STATUS);
  endfunction : addr_mapped

  // delay cycles chosen by the start-up fuses
  function automatic logic [`SCTP_DLY_W-1:0] reset_delay(
    input logic [1:0] startup_time_fuses);
    unique case (startup_time_fuses)
      `SCTP_SUT_NONE: reset_delay = '0;
      `SCTP_SUT_SHORT: reset_delay = `SCTP_DLY_W'(DLY_SHORT_CYC);
      `SCTP_SUT_LONG: reset_delay = `SCTP_DLY_W'(DLY_LONG_CYC);
      default: reset_delay = `SCTP_DLY_W'(DLY_LONG_CYC);
    endcase
  endfunction : reset_delay

  // fuses and calibration byte come from outside the pclk domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_s1_ff <= '0;
      fuse_ff <= '0;
      cal_s1_ff <= 8'h00;
      cal_ff <= 8'h00;
    end else begin
      fuse_s1_ff <= fuse_in;
      fuse_ff <= fuse_s1_ff;
      cal_s1_ff <= calibration_byte;
      cal_ff <= cal_s1_ff;
    end
  end

  // sync wait, one load cycle, then the fuse-selected reset delay
  always_comb begin
    nxt_state = state_ff;
    nxt_dly_cnt = dly_cnt_ff;
    unique case (state_ff)
      sctp_pkg::ST_SYNC: begin
        nxt_dly_cnt = dly_cnt_ff + `SCTP_DLY_W'(1);
        if (dly_cnt_ff[1:0] == `SCTP_SYNC_CYC - 2'h1) begin
          nxt_state = sctp_pkg::ST_LOAD;
        end
      end
      sctp_pkg::ST_LOAD: begin
        nxt_dly_cnt = reset_delay(fuse_ff.startup_time);
        nxt_state = sctp_pkg::ST_DELAY;
      end
      sctp_pkg::ST_DELAY: begin
        if (dly_cnt_ff == '0) begin
          nxt_state = sctp_pkg::ST_RUN;
        end else begin
          nxt_dly_cnt = dly_cnt_ff - `SCTP_DLY_W'(1);
        end
      end
      sctp_pkg::ST_RUN: begin
        nxt_dly_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= sctp_pkg::ST_SYNC;
      dly_cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      dly_cnt_ff <= nxt_dly_cnt;
    end
  end

  // a write lands only at the edge that completes the access phase
  assign acc = psel && penable && !pready_ff;
  assign wr_go = psel && penable && pready_ff && pwrite && pstrb[0];
  assign wbyte = pwdata[7:0];

  // register file, unlock window and apb answer
  always_comb begin
    nxt_trim = trim_ff;
    nxt_sel = sel_ff;
    nxt_tsync = tsync_ff;
    nxt_win = (win_ff != 3'h0) ? win_ff - 3'h1 : 3'h0;
    nxt_pready = acc;
    nxt_pslverr = acc && !addr_mapped(paddr);
    nxt_prdata = 32'h0000_0000;
    if (state_ff == sctp_pkg::ST_LOAD) begin
      nxt_trim = cal_ff;
      nxt_sel = fuse_ff.initial_divide ? `SCTP_SEL_FUSE_INIT
                                       : `SCTP_SEL_DIV1;
    end else if (wr_go) begin
      unique case (paddr)
        `SCTP_OFS_TRIM: nxt_trim = wbyte;
        `SCTP_OFS_DIVCTL: begin
          if (wbyte == `SCTP_UNLOCK_PATTERN) begin
            nxt_win = `SCTP_UNLOCK_CYC;
          end else if (win_ff != 3'h0 && !wbyte[`SCTP_UNLOCK_BIT]) begin
            nxt_sel = wbyte[`SCTP_SEL_MSB:0];
            nxt_win = 3'h0;
          end else begin
            nxt_win = 3'h0;
          end
        end
        `SCTP_OFS_CFG: nxt_tsync = wbyte[`SCTP_CFG_TSYNC_BIT];
        default: ;
      endcase
    end
    if (acc && !pwrite) begin
      unique case (paddr)
        `SCTP_OFS_TRIM: nxt_prdata[7:0] = trim_ff;
        `SCTP_OFS_DIVCTL: begin
          nxt_prdata[`SCTP_UNLOCK_BIT] = (win_ff != 3'h0);
          nxt_prdata[`SCTP_SEL_MSB:0] = sel_ff;
        end
        `SCTP_OFS_CFG: nxt_prdata[`SCTP_CFG_TSYNC_BIT] = tsync_ff;
        `SCTP_OFS_STATUS: begin
          nxt_prdata[7:0] = fuse_ff;
          nxt_prdata[`SCTP_ST_DONE_BIT] = (state_ff == sctp_pkg::ST_RUN);
          nxt_prdata[`SCTP_ST_EXT_BIT] = ext_sel_ff;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_ff <= 8'h00;
      sel_ff <= `SCTP_SEL_DIV1;
      tsync_ff <= 1'b0;
      win_ff <= 3'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      trim_ff <= nxt_trim;
      sel_ff <= nxt_sel;
      tsync_ff <= nxt_tsync;
      win_ff <= nxt_win;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // divider steps factors only at period ends
  sctp_divider #(
    .CNT_W(8)
  ) u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .div_sel(sel_ff),
    .tick(div_tick),
    .div_clk(div_clk)
  );

  // wake from power-down: fixed count whatever the source
  always_comb begin
    nxt_wake_cnt = wake_cnt_ff;
    nxt_wake_ready = 1'b0;
    if (wake_request && wake_cnt_ff == 3'h0) begin
      nxt_wake_cnt = `SCTP_WAKE_CK;
    end else if (wake_cnt_ff != 3'h0) begin
      nxt_wake_cnt = wake_cnt_ff - 3'h1;
      nxt_wake_ready = (wake_cnt_ff == 3'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt_ff <= 3'h0;
      wake_ready_ff <= 1'b0;
    end else begin
      wake_cnt_ff <= nxt_wake_cnt;
      wake_ready_ff <= nxt_wake_ready;
    end
  end

  // clock enables, clock pin and interrupt block, all registered;
  // the pin is a square wave at half the tick rate, since a flop
  // cannot reproduce pclk itself at factor one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_en_ff <= 1'b0;
      timer_en_ff <= 1'b0;
      clkout_ff <= 1'b0;
      clkout_oe_ff <= 1'b0;
      ext_sel_ff <= 1'b0;
      irq_block_ff <= 1'b0;
    end else begin
      sys_en_ff <= div_tick;
      timer_en_ff <= tsync_ff ? div_tick : 1'b1;
      clkout_ff <= div_clk;
      clkout_oe_ff <= fuse_ff.clock_output;
      ext_sel_ff <= (fuse_ff.source_sel == `SCTP_SRC_EXTERNAL);
      irq_block_ff <= (nxt_win != 3'h0);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign trim_value = trim_ff;
  assign ext_clock_select = ext_sel_ff;
  assign startup_done = (state_ff == sctp_pkg::ST_RUN);
  assign wake_ready = wake_ready_ff;
  assign sys_clock_en = sys_en_ff;
  assign async_timer_clock_en = timer_en_ff;
  assign irq_block = irq_block_ff;
  assign portb0_out = clkout_ff;
  assign portb0_oe = clkout_oe_ff;

endmodule : sctp_top

/* File: tb/sctp_chk.sv */
/*
  concurrent checks on the sctp_top ports: apb timing, unlock window,
  trim load and clock output enable; assumes one pclk domain
*/
`timescale 1ns/1ps
module sctp_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire sctp_pkg::sctp_fuse_type fuse_in,
  input wire logic [7:0] calibration_byte,
  input wire logic [7:0] trim_value,
  input wire logic startup_done,
  input wire logic irq_block,
  input wire logic portb0_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed write to divide control; a masked strobe is no write
  wire logic dwr = psel && penable && pready && pwrite && pstrb[0] &&
    paddr == 12'h004;
  sequence unlock_wr;
    dwr && pwdata[7:0] == 8'h80;
  endsequence
  sequence quiet4;
    (!dwr) [*4];
  endsequence

  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_RDY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  AST_ERR_MAP: assert property (pready |-> pslverr == (paddr > 12'h00C))
    else $error("pslverr wrong");
  AST_TRIM_LOAD: assert property ($rose(presetn) |-> ##3
    trim_value == calibration_byte) else $error("trim not loaded");
  AST_UNLOCK: assert property (unlock_wr |=> irq_block)
    else $error("window not opened");
  AST_WIN_END: assert property (unlock_wr ##1 quiet4 |=> !irq_block)
    else $error("window too long");
  AST_WR_CLOSE: assert property (dwr && pwdata[7:0] != 8'h80 |=>
    !irq_block) else $error("window not closed");
  AST_DIV_RD: assert property (pready && !pwrite && paddr == 12'h004 |->
    prdata[31:8] == 24'h00_0000 && prdata[6:4] == 3'h0)
    else $error("reserved bits set");
  AST_OE_FUSE: assert property (startup_done |->
    portb0_oe == fuse_in.clock_output) else $error("clock output wrong");
endmodule : sctp_chk

bind sctp_top sctp_chk u_sctp_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .fuse_in(fuse_in),
  .calibration_byte(calibration_byte), .trim_value(trim_value),
  .startup_done(startup_done), .irq_block(irq_block),
  .portb0_oe(portb0_oe));

/* File: tb/sctp_tb_top.sv */
/*
  self-checking bench for sctp_top: register table, timed unlock,
  divider periods and three resets; assumes the sctp_regs.svh figures
*/
`timescale 1ns/1ps
module sctp_tb_top;
  typedef struct packed {
    logic [11:0] a;
    logic [3:0] s;
    logic [31:0] w;
    logic [31:0] r;
    logic e;
  } sctp_row_type;
  // write then read back each row; no flash write runs, so top trim is safe
  sctp_row_type rows [8] = '{
    '{12'h000, 4'hF, 32'h0000_007F, 32'h0000_007F, 1'h0},
    '{12'h000, 4'hF, 32'h0000_0000, 32'h0000_0000, 1'h0},
    '{12'h000, 4'hE, 32'h0000_0011, 32'h0000_0000, 1'h0},
    '{12'h004, 4'hF, 32'h0000_0003, 32'h0000_0004, 1'h0},
    '{12'h004, 4'hF, 32'hFFFF_FF70, 32'h0000_0004, 1'h0},
    '{12'h00C, 4'hF, 32'h0000_0000, 32'h0000_0303, 1'h0},
    '{12'h010, 4'hF, 32'h0000_0055, 32'h0000_0000, 1'h1},
    '{12'h008, 4'hF, 32'h0000_0001, 32'h0000_0001, 1'h0}};
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, wake_request = 1'h0, pready, pslverr, er, p;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] trim_value;
  sctp_pkg::sctp_fuse_type fuse_in = 8'h03;
  logic [7:0] cal = 8'h5A;
  logic ext_clock_select, startup_done, wake_ready, sys_clock_en;
  logic async_timer_clock_en, irq_block, portb0_out, portb0_oe;
  int miscompares = 0, cmp_count = 0, n0, n1, n;

  // short delays keep the start-up runs brief
  sctp_top #(.DLY_SHORT_CYC(20), .DLY_LONG_CYC(50)) u_sctp_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fuse_in(fuse_in), .calibration_byte(cal),
    .wake_request(wake_request), .trim_value(trim_value),
    .ext_clock_select(ext_clock_select), .startup_done(startup_done),
    .wake_ready(wake_ready), .sys_clock_en(sys_clock_en),
    .async_timer_clock_en(async_timer_clock_en), .irq_block(irq_block),
    .portb0_out(portb0_out), .portb0_oe(portb0_oe));

  // fixed period: the clock never steps in frequency
  always #5 pclk = ~pclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  // keep holds psel so a setup follows at once, the value write landing three edges after the unlock instead of four
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s, input bit keep);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    // request stands until pready is seen at a rising edge
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    penable <= 1'h0;
    if (!keep) psel <= 1'h0;
    if (!keep) @(posedge pclk);
  endtask : apb

  // one divided period; outputs sampled mid-cycle where settled
  task automatic per(input logic ts);
    int bad;
    bad = 0;
    do @(negedge pclk); while (sys_clock_en !== 1'h1);
    p = portb0_out;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
      if (async_timer_clock_en !== (ts ? sys_clock_en : 1'h1)) bad++;
    end while (sys_clock_en !== 1'h1);
    chk(bad, 0);
    chk(portb0_out ^ p, 1);
    // return on a rising edge so the next drive lands there
    @(posedge pclk);
  endtask : per

  task automatic rst(output int c);
    presetn <= 1'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    c = 0;
    while (startup_done !== 1'h1 && c < 200) begin
      @(negedge pclk);
      c++;
    end
    chk(startup_done, 1'h1);
    @(posedge pclk);
  endtask : rst

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // watchdog far beyond the longest expected run
  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    complete_run();
  end

  initial begin
    rst(n0);
    chk(trim_value, 8'h5A);
    chk(ext_clock_select, 1'h1);
    chk(portb0_oe, 1'h1);
    apb(0, 12'h004, 0, 4'hF, 0);
    chk(rd, 32'h0000_0004);
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].w, rows[i].s, 0);
      apb(0, rows[i].a, 0, 4'hF, 0);
      chk(rd, rows[i].r);
      chk(er, rows[i].e);
    end
    $display("register test done");
    for (int c = 0; c < 10; c++) begin
      // no interrupt can fall between the two steps here
      apb(1, 12'h004, 32'h0000_0080, 4'hF, 1);
      apb(1, 12'h004, c, 4'hF, 0);
      apb(0, 12'h004, 0, 4'hF, 0);
      chk(rd, c);
      per(1);
      per(1);
      chk(n, c > 8 ? 256 : 1 << c);
    end
    $display("divider test done");
    // value write landing four edges after the unlock is still inside
    apb(1, 12'h004, 32'h0000_0080, 4'hF, 0);
    apb(1, 12'h004, 32'h0000_0002, 4'hF, 0);
    apb(0, 12'h004, 0, 4'hF, 0);
    chk(rd, 32'h0000_0002);
    // one edge later the window has lapsed
    apb(1, 12'h004, 32'h0000_0080, 4'hF, 0);
    @(posedge pclk);
    apb(1, 12'h004, 32'h0000_0005, 4'hF, 0);
    apb(0, 12'h004, 0, 4'hF, 0);
    chk(rd, 32'h0000_0002);
    apb(1, 12'h008, 0, 4'hF, 0);
    per(0);
    $display("late unlock test done");
    fuse_in <= 8'h24;
    cal <= 8'hA5;
    rst(n1);
    chk(n1 - n0, 20);
    chk(trim_value, 8'hA5);
    chk(ext_clock_select, 1'h0);
    chk(portb0_oe, 1'h0);
    apb(0, 12'h004, 0, 4'hF, 0);
    chk(rd, 32'h0000_0000);
    wake_request <= 1'h1;
    @(posedge pclk);
    wake_request <= 1'h0;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (wake_ready !== 1'h1 && n < 20);
    chk(n >= 6 && n <= 7, 1);
    $display("second reset test done");
    // long start-up delay code
    @(posedge pclk);
    fuse_in <= 8'h08;
    rst(n);
    chk(n - n0, 50);
    $display("long delay test done");
    complete_run();
  end
endmodule : sctp_tb_top
